// >>> common/fmcc_pkg.sv
// Package for the floppy mode command configuration block.
// Assumes one 250 MHz clock domain and an AXI4-Lite register bus.
package fmcc_pkg;
  // ********************************************************
  // Register byte addresses
  // ********************************************************
  localparam logic [7:0] OFF_CMD = 8'h00;
  localparam logic [7:0] OFF_RESULT = 8'h04;
  localparam logic [7:0] OFF_CFG0 = 8'h08;
  localparam logic [7:0] OFF_CFG1 = 8'h0C;
  localparam logic [7:0] OFF_CTRL = 8'h10;
  localparam logic [7:0] OFF_STATUS = 8'h14;
  localparam logic [7:0] OFF_DERIVED = 8'h18;
  // ********************************************************
  // Opcodes and result codes
  // ********************************************************
  localparam logic [7:0] OP_MODE = 8'h01;
  localparam logic [7:0] OP_IDENTIFY = 8'h18;
  localparam logic [7:0] ST0_INVALID = 8'h80;
  // Identification nibbles, arbitrary values
  localparam logic [3:0] ID_UPPER = 4'h5;
  localparam logic [3:0] ID_VERSION = 4'h1;
  // ********************************************************
  // Reset values
  // ********************************************************
  localparam logic [3:0] SETTLE_RESET = 4'h8;
  localparam logic [1:0] DENS_RESET = 2'h3;
  // Recalibrate limits
  localparam logic [11:0] RECAL_85 = 12'h055;
  localparam logic [11:0] RECAL_255 = 12'h0FF;
  localparam logic [11:0] RECAL_3925 = 12'hF55;
  localparam logic [11:0] RECAL_4095 = 12'hFFF;
  // Data rate codes
  localparam logic [1:0] RATE_500K = 2'h0;
  localparam logic [1:0] RATE_300K = 2'h1;
  localparam logic [1:0] RATE_250K = 2'h2;
  localparam logic [1:0] RATE_TOP = 2'h3;
  // Settle units in microseconds, per rate
  localparam logic [15:0] SETTLE_US_250 = 16'h1F40;
  localparam logic [15:0] SETTLE_US_300 = 16'h1A0A;
  localparam logic [15:0] SETTLE_US_500 = 16'h0FA0;
  localparam logic [15:0] SETTLE_US_TOP = 16'h07D0;
  localparam logic [15:0] LOWPWR_MS_500 = 16'h0200;
  localparam logic [15:0] LOWPWR_MS_250 = 16'h03E8;
  localparam logic [1:0] LP_OFF = 2'h0;
  localparam logic [1:0] LP_AUTO = 2'h1;
  localparam logic [1:0] LP_NOW = 2'h2;

  typedef enum logic [2:0] {
    FMCC_IDLE = 3'b000,
    FMCC_PARAM = 3'b001,
    FMCC_RESULT = 3'b010
  } fmcc_phase_e;

  typedef struct packed {
    logic motor_timer_select;
    logic index_field_omit;
    logic implied_seek_honour;
    logic [1:0] low_power_select;
    logic extended_track_range;
    logic fifo_write_disable;
    logic fifo_read_disable;
    logic burst_disable;
    logic recal_limit_select;
    logic [1:0] density_select;
    logic output_drive_type;
    logic scan_wildcard_disable;
    logic [3:0] settle_count;
    logic read_gate_diag;
    logic pump_output_diag;
  } fmcc_opts_s;
endpackage

// >>> rtl/fmcc_top.sv
// Mode command interpreter and identification query with AXI4-Lite access.
// Assumes a host writes command bytes to CMD and reads result bytes from RESULT;
// the lock, FIFO enable, data rate and tape setup come from neighbour logic.
//
// Decided for this implementation: the address map and register access over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none
// How it works
// - Mode opcode plus four bytes updates options; no disk action, no result bytes.
// - Motor timer select picks timer definition one (0, default) or two (1).
// - Index field omit 1 formats without index field; 0 includes it.
// - Implied seek honour gates per-command seek bit; global enable still applies.
// - Low power 00 off, 01 auto after delay, 10 immediately, 11 unused.
// - Extended track range gives 12-bit tracks, upper nibble in head byte.
// - FIFO write disable bypasses FIFO for host writes only when FIFO enabled.
// - FIFO read disable bypasses FIFO for host reads only when FIFO enabled.
// - Software reset defaults FIFO write, read, burst disables only when unlocked.
// - Burst disable with FIFO on strobes request line once per byte.
// - Recalibrate limit 85 or 255, or 3925 or 4095 with extended range.
// - Default density output follows drive type input and selected data rate.
// - Density field: 00 low, 01 high, 10 undefined, 11 default behaviour.
// - Output drive type 1 gives open-drain outputs, 0 gives push-pull.
// - Scan wildcard disable 0 lets FFh always match; 1 compares normally.
// - Head settle count (default 8) times rate unit sets settle wait.
// - Read gate diag turns disk change input into external read gate.
// - Pump diag routes internal serial data-in onto encoded write output.
// - Identify query returns one byte; low nibble holds the version.
// - Top data rate code means 1 Mbps when tape setup bit 1 is 0.
// - Top data rate code means 2 Mbps when tape setup bit 1 is 1.
module fmcc_top import fmcc_pkg::*; #(
  parameter int RECAL_W = 12
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Neighbour controller state, same clock
  input wire logic soft_reset,
  input wire logic param_lock,
  input wire logic fifo_enable,
  input wire logic global_implied_seek,
  input wire logic cmd_implied_seek,
  input wire logic [1:0] data_rate,
  input wire logic [1:0] tape_setup,
  input wire logic head_unload_expired,
  input wire logic xfer_byte,
  // Pins from outside
  input wire logic drive_type_in,
  input wire logic disk_change_input,
  // Pins and derived controls
  output logic density_select_out,
  output logic output_open_drain,
  output logic disk_change_sense,
  output logic ext_read_gate,
  output logic encoded_write_sel_pump,
  output logic seek_before_cmd,
  output logic fifo_write_path,
  output logic fifo_read_path,
  output logic request_strobe,
  output logic low_power_now,
  output logic [RECAL_W-1:0] recal_limit,
  output logic [15:0] settle_unit_us,
  output logic top_rate_2m,
  output fmcc_opts_s opts
);
  // ********************************************************
  // Pin synchronisers
  // ********************************************************
  logic [1:0] ident_sync;
  logic [1:0] disk_change_input_sync;
  always_ff @(posedge aclk) begin
    ident_sync <= {ident_sync[0], drive_type_in};
    disk_change_input_sync <= {disk_change_input_sync[0], disk_change_input};
  end
  wire ident_q = ident_sync[1];
  wire disk_change_input_q = disk_change_input_sync[1];

  // ********************************************************
  // AXI4-Lite slave
  // ********************************************************
  logic aw_held, w_held;
  logic [7:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  wire do_write = aw_held && w_held && !s_axi_bvalid;
  wire wr_cmd = do_write && aw_addr == OFF_CMD && w_strb[0];
  wire wr_ctrl = do_write && aw_addr == OFF_CTRL && w_strb[0];
  wire wr_known = aw_addr == OFF_CMD || aw_addr == OFF_CTRL;
  assign s_axi_awready = !aw_held;
  assign s_axi_wready = !w_held;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 8'h00;
      w_data <= 32'h0;
      w_strb <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'b00;
    end else begin
      if (s_axi_awvalid && !aw_held) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && !w_held) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (do_write) begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_known ? 2'b00 : 2'b10;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // ********************************************************
  // Command interpreter
  // ********************************************************
  fmcc_phase_e phase;
  logic [1:0] byte_idx;
  logic [7:0] result_byte;
  logic [7:0] p1, p2, p3;
  fmcc_opts_s next_opts;
  logic hw_start;
  wire [7:0] cmd_byte = w_data[7:0];
  wire rd_result = s_axi_arvalid && s_axi_arready && s_axi_araddr == OFF_RESULT
                   && phase == FMCC_RESULT;
  wire last_param = wr_cmd && phase == FMCC_PARAM && byte_idx == 2'd3;

  // Assemble the full option word from the four parameter bytes
  always_comb begin
    next_opts = opts;
    next_opts.motor_timer_select = p1[7];
    next_opts.index_field_omit = p1[6];
    next_opts.implied_seek_honour = p1[5];
    next_opts.low_power_select = p1[3:2];
    next_opts.extended_track_range = p1[0];
    next_opts.fifo_write_disable = p2[7];
    next_opts.fifo_read_disable = p2[6];
    next_opts.burst_disable = p2[5];
    next_opts.recal_limit_select = p2[4];
    next_opts.density_select = p3[7:6];
    next_opts.output_drive_type = p3[5];
    next_opts.scan_wildcard_disable = p3[4];
    next_opts.settle_count = p3[3:0];
    next_opts.read_gate_diag = w_data[0];
    next_opts.pump_output_diag = w_data[2];
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      phase <= FMCC_IDLE;
      byte_idx <= 2'd0;
      result_byte <= 8'h00;
      p1 <= 8'h00;
      p2 <= 8'h00;
      p3 <= 8'h00;
    end else if (soft_reset) begin
      phase <= FMCC_IDLE;
      byte_idx <= 2'd0;
    end else begin
      unique case (phase)
        FMCC_IDLE: begin
          if (wr_cmd) begin
            if (cmd_byte == OP_MODE) begin
              phase <= FMCC_PARAM;
              byte_idx <= 2'd0;
            end else if (cmd_byte == OP_IDENTIFY) begin
              result_byte <= {ID_UPPER, ID_VERSION};
              phase <= FMCC_RESULT;
            end else begin
              result_byte <= ST0_INVALID;
              phase <= FMCC_RESULT;
            end
          end
        end
        FMCC_PARAM: begin
          if (wr_cmd) begin
            byte_idx <= byte_idx + 2'd1;
            if (byte_idx == 2'd0) p1 <= w_data[7:0];
            if (byte_idx == 2'd1) p2 <= w_data[7:0];
            if (byte_idx == 2'd2) p3 <= w_data[7:0];
            // Mode ends straight back in idle, no result phase
            if (byte_idx == 2'd3) phase <= FMCC_IDLE;
          end
        end
        FMCC_RESULT: begin
          if (rd_result) phase <= FMCC_IDLE;
        end
        default: phase <= FMCC_IDLE;
      endcase
    end
  end

  // Option register: hardware reset to defaults, soft reset by lock
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      opts <= '0;
      opts.settle_count <= SETTLE_RESET;
      opts.density_select <= DENS_RESET;
    end else if (last_param) begin
      opts <= next_opts;
    end else if (soft_reset) begin
      opts.motor_timer_select <= 1'b0;
      opts.index_field_omit <= 1'b0;
      opts.implied_seek_honour <= 1'b0;
      opts.low_power_select <= LP_OFF;
      opts.extended_track_range <= 1'b0;
      opts.recal_limit_select <= 1'b0;
      if (!param_lock) begin
        opts.fifo_write_disable <= 1'b0;
        opts.fifo_read_disable <= 1'b0;
        opts.burst_disable <= 1'b0;
      end
    end
  end
  wire unused_ok = hw_start;
  assign hw_start = 1'b0;

  // ********************************************************
  // Derived controls
  // ********************************************************
  wire fast_rate = data_rate == RATE_500K || data_rate == RATE_TOP;
  wire [1:0] lp_code = opts.low_power_select;
  logic [RECAL_W-1:0] next_recal;
  logic [15:0] next_unit;
  logic next_dens;
  always_comb begin
    unique case ({opts.extended_track_range, opts.recal_limit_select})
      2'b00: next_recal = RECAL_85[RECAL_W-1:0];
      2'b01: next_recal = RECAL_255[RECAL_W-1:0];
      2'b10: next_recal = RECAL_3925[RECAL_W-1:0];
      default: next_recal = RECAL_4095[RECAL_W-1:0];
    endcase
    unique case (data_rate)
      RATE_250K: next_unit = SETTLE_US_250;
      RATE_300K: next_unit = SETTLE_US_300;
      RATE_500K: next_unit = SETTLE_US_500;
      default: next_unit = SETTLE_US_TOP;
    endcase
    unique case (opts.density_select)
      2'b00: next_dens = 1'b0;
      2'b01: next_dens = 1'b1;
      2'b10: next_dens = 1'b0;
      default: next_dens = ident_q ? fast_rate : !fast_rate;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      recal_limit <= '0;
      settle_unit_us <= 16'h0;
      density_select_out <= 1'b0;
      low_power_now <= 1'b0;
      top_rate_2m <= 1'b0;
    end else begin
      recal_limit <= next_recal;
      settle_unit_us <= next_unit;
      density_select_out <= next_dens;
      top_rate_2m <= tape_setup[1];
      // Auto entry uses a neighbour timer flag; codes 00 and 11 stay awake
      low_power_now <= lp_code == LP_NOW || (lp_code == LP_AUTO && head_unload_expired);
    end
  end

  assign output_open_drain = opts.output_drive_type;
  assign ext_read_gate = opts.read_gate_diag & disk_change_input_q;
  assign disk_change_sense = !opts.read_gate_diag & disk_change_input_q;
  assign encoded_write_sel_pump = opts.pump_output_diag;
  assign seek_before_cmd = global_implied_seek
                           | (opts.implied_seek_honour & cmd_implied_seek);
  assign fifo_write_path = fifo_enable & !opts.fifo_write_disable;
  assign fifo_read_path = fifo_enable & !opts.fifo_read_disable;
  // Per-byte strobe only in non-burst FIFO mode
  assign request_strobe = fifo_enable & opts.burst_disable & xfer_byte;

  // ********************************************************
  // AXI4-Lite read path
  // ********************************************************
  logic [31:0] next_rdata;
  logic rd_ok;
  assign s_axi_arready = !s_axi_rvalid;
  always_comb begin
    rd_ok = 1'b1;
    unique case (s_axi_araddr)
      OFF_RESULT: next_rdata = {24'h0, result_byte};
      OFF_CFG0: next_rdata = {24'h0, opts.motor_timer_select, opts.index_field_omit,
                              opts.implied_seek_honour, 1'b0, opts.low_power_select,
                              1'b1, opts.extended_track_range};
      OFF_CFG1: next_rdata = {16'h0, opts.density_select, opts.output_drive_type,
                              opts.scan_wildcard_disable, opts.settle_count,
                              opts.fifo_write_disable, opts.fifo_read_disable,
                              opts.burst_disable, opts.recal_limit_select, 4'h0};
      OFF_CTRL: next_rdata = {29'h0, opts.pump_output_diag, 1'b0, opts.read_gate_diag};
      OFF_STATUS: next_rdata = {27'h0, top_rate_2m, low_power_now,
                                phase == FMCC_RESULT, phase == FMCC_PARAM, unused_ok};
      OFF_DERIVED: next_rdata = {settle_unit_us, 4'h0, recal_limit};
      default: begin
        next_rdata = 32'h0;
        rd_ok = 1'b0;
      end
    endcase
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= 2'b00;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= next_rdata;
      s_axi_rresp <= rd_ok ? 2'b00 : 2'b10;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // Writes to CTRL are acknowledged but leave the diagnostic bits unchanged
  wire unused_ctrl = wr_ctrl;
endmodule
`default_nettype wire

// >>> sim/fmcc_properties.sv
// Concurrent checks on the mode configuration block ports.
// Assumes a bind into fmcc_top, one clock, aresetn active low.
`timescale 1ns/1ps
`default_nettype none
module fmcc_checker import fmcc_pkg::*; #(
  parameter int RECAL_W = 12
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Neighbour state
  input wire logic soft_reset,
  input wire logic param_lock,
  input wire logic fifo_enable,
  input wire logic global_implied_seek,
  input wire logic cmd_implied_seek,
  input wire logic xfer_byte,
  input wire logic [1:0] data_rate,
  input wire logic [1:0] tape_setup,
  // Derived outputs
  input wire logic density_select_out,
  input wire logic output_open_drain,
  input wire logic seek_before_cmd,
  input wire logic fifo_write_path,
  input wire logic fifo_read_path,
  input wire logic request_strobe,
  input wire logic low_power_now,
  input wire logic [RECAL_W-1:0] recal_limit,
  input wire logic [15:0] settle_unit_us,
  input wire logic top_rate_2m,
  input wire logic ext_read_gate,
  input wire logic disk_change_sense,
  input wire logic encoded_write_sel_pump,
  input wire fmcc_opts_s opts
);
  // ****************************************
  // Expected derived values
  // ****************************************
  logic [11:0] exp_recal;
  logic [15:0] exp_unit;
  assign exp_recal = opts.recal_limit_select ?
    (opts.extended_track_range ? RECAL_4095 : RECAL_255) :
    (opts.extended_track_range ? RECAL_3925 : RECAL_85);
  assign exp_unit = data_rate == RATE_250K ? SETTLE_US_250 :
    data_rate == RATE_300K ? SETTLE_US_300 :
    data_rate == RATE_500K ? SETTLE_US_500 : SETTLE_US_TOP;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  chk_drive_type: assert property (output_open_drain == opts.output_drive_type)
    else $error("open drain select wrong");
  chk_seek_gate: assert property (seek_before_cmd ==
    (global_implied_seek | (opts.implied_seek_honour & cmd_implied_seek)))
    else $error("seek gate wrong");
  chk_fifo_wr_path: assert property (fifo_enable |-> fifo_write_path == !opts.fifo_write_disable)
    else $error("fifo write path wrong");
  chk_fifo_rd_path: assert property (fifo_enable |-> fifo_read_path == !opts.fifo_read_disable)
    else $error("fifo read path wrong");
  chk_burst_strobe: assert property (fifo_enable && opts.burst_disable |->
    request_strobe == xfer_byte) else $error("byte strobe wrong");
  chk_recal_limit: assert property ($past(aresetn) |-> recal_limit == $past(exp_recal))
    else $error("recal limit wrong");
  chk_top_rate: assert property ($past(aresetn) |-> top_rate_2m == $past(tape_setup[1]))
    else $error("top rate wrong");
  chk_settle_unit: assert property ($past(aresetn) |-> settle_unit_us == $past(exp_unit))
    else $error("settle unit wrong");
  chk_lowpower_now: assert property (opts.low_power_select == LP_NOW |-> ##[0:1] low_power_now)
    else $error("low power entry late");
  chk_soft_locked: assert property (soft_reset && param_lock |=>
    $stable({opts.fifo_write_disable, opts.fifo_read_disable, opts.burst_disable}))
    else $error("locked bits lost");
  chk_soft_unlock: assert property (soft_reset && !param_lock |=>
    {opts.fifo_write_disable, opts.fifo_read_disable, opts.burst_disable} == 3'h0)
    else $error("unlocked bits kept");
  chk_density_fixed: assert property (opts.density_select == 2'h1 &&
    $past(opts.density_select) == 2'h1 |-> density_select_out) else $error("density not high");
  chk_lowpower_off: assert property (opts.low_power_select == LP_OFF &&
    $past(opts.low_power_select) == LP_OFF |-> !low_power_now) else $error("low power while off");
  chk_read_gate: assert property ((ext_read_gate |-> opts.read_gate_diag) and
    (disk_change_sense |-> !opts.read_gate_diag)) else $error("read gate routing wrong");
  chk_pump_diag: assert property (encoded_write_sel_pump == opts.pump_output_diag)
    else $error("pump diag select wrong");
  cover property (soft_reset && param_lock);
  cover property (request_strobe);
  cover property (low_power_now);
endmodule
bind fmcc_top fmcc_checker #(.RECAL_W(RECAL_W)) fmcc_checker_i (.*);
`default_nettype wire

// >>> sim/fmcc_host_model.sv
// Host side AXI4-Lite master that feeds command bytes.
// Assumes the caller seeds $urandom; one transfer at a time.
`timescale 1ns/1ps
`default_nettype none
module fmcc_host_model (
  // Clock
  input wire logic aclk,
  // Write channels
  output logic [7:0] s_axi_awaddr, output logic s_axi_awvalid, input wire logic s_axi_awready,
  output logic [31:0] s_axi_wdata, output logic [3:0] s_axi_wstrb,
  output logic s_axi_wvalid, input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp, input wire logic s_axi_bvalid, output logic s_axi_bready,
  // Read channels
  output logic [7:0] s_axi_araddr, output logic s_axi_arvalid, input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata, input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid, output logic s_axi_rready
);
  initial begin
    {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wstrb, s_axi_wvalid} = '0;
    {s_axi_bready, s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
  end
  // Random idle gap exercises slow hosts
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    repeat ($urandom_range(2)) @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= 4'hF;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    forever begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bready <= 1'b0;
        s_axi_awaddr <= ~a;
        s_axi_wdata <= ~d;
        break;
      end
    end
  endtask
  task automatic rd(input logic [7:0] a);
    repeat ($urandom_range(2)) @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    forever begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rready <= 1'b0;
        s_axi_araddr <= ~a;
        break;
      end
    end
  endtask
endmodule
`default_nettype wire

// >>> sim/fmcc_tb_top.sv
// Self-checking bench for the mode configuration block.
// Assumes the host model and the bound checker are compiled alongside.
`timescale 1ns/1ps
`default_nettype none
module fmcc_tb_top import fmcc_pkg::*; ;
  logic aclk = 1'b0, aresetn = 1'b0;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, data_rate, tape_setup;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic soft_reset, param_lock, fifo_enable, global_implied_seek, cmd_implied_seek;
  logic head_unload_expired, xfer_byte, drive_type_in, disk_change_input;
  logic density_select_out, output_open_drain, disk_change_sense, ext_read_gate;
  logic encoded_write_sel_pump, seek_before_cmd, fifo_write_path, fifo_read_path;
  logic request_strobe, low_power_now, top_rate_2m;
  logic [11:0] recal_limit;
  logic [15:0] settle_unit_us;
  fmcc_opts_s opts, e;
  logic [7:0] b2, b3, b4, b5;
  logic [33:0] rd_q[$], rn;
  logic [1:0] wr_q[$];
  int num_errors = 0, checks = 0;
  fmcc_top fmcc_top_i (.*);
  fmcc_host_model fmcc_host_model_i (.*);
  always #2 aclk = ~aclk;
  // ****************************************
  // Checking helpers
  // ****************************************
  task automatic final_report;
    $display("checks %0d errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic cmp(string what, logic [31:0] exp, logic [31:0] got);
    checks++;
    if (exp !== got) begin
      num_errors++;
      $display("unexpected %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic bus_wr(logic [7:0] a, logic [7:0] b, logic [1:0] resp);
    wr_q.push_back(resp);
    fmcc_host_model_i.wr(a, {24'h0, b});
  endtask
  task automatic bus_rd(logic [7:0] a, logic [33:0] exp);
    rd_q.push_back(exp);
    fmcc_host_model_i.rd(a);
  endtask
  function automatic fmcc_opts_s exp_opts(logic [7:0] c2, c3, c4, c5);
    return {c2[7:5], c2[3:2], c2[0], c3[7:4], c4, c5[0], c5[2]};
  endfunction
  task automatic mode_cmd(logic [7:0] c2, c3, c4, c5);
    bus_wr(OFF_CMD, OP_MODE, 2'h0);
    bus_wr(OFF_CMD, c2, 2'h0);
    bus_wr(OFF_CMD, c3, 2'h0);
    bus_wr(OFF_CMD, c4, 2'h0);
    bus_wr(OFF_CMD, c5, 2'h0);
    @(posedge aclk);
  endtask
  // Oldest note is matched against each bus answer
  always @(posedge aclk) begin
    if (s_axi_bvalid && s_axi_bready) cmp("bresp", wr_q.pop_front(), s_axi_bresp);
    if (s_axi_rvalid && s_axi_rready) begin
      rn = rd_q.pop_front();
      cmp("rresp", rn[33:32], s_axi_rresp);
      cmp("rdata", rn[31:0], s_axi_rdata);
    end
  end
  // Side inputs toggle freely so the path checks see traffic
  always @(posedge aclk) begin
    {fifo_enable, global_implied_seek, cmd_implied_seek, xfer_byte,
      head_unload_expired, disk_change_input} <= 6'($urandom);
  end
  initial begin
    repeat (30000) @(posedge aclk);
    num_errors++;
    final_report;
  end
  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    {soft_reset, param_lock, drive_type_in, data_rate, tape_setup} = '0;
    void'($urandom(74401));
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    e = '0;
    e.settle_count = SETTLE_RESET;
    e.density_select = DENS_RESET;
    cmp("opts", 32'(e), 32'(opts));
    for (int i = 0; i < 8; i++) begin
      data_rate <= i[1:0];
      drive_type_in <= i[2];
      repeat (6) @(posedge aclk);
      cmp("density", 32'(i[2] ^ (i[1:0] == RATE_250K || i[1:0] == RATE_300K)),
        32'(density_select_out));
    end
    bus_wr(OFF_CMD, OP_IDENTIFY, 2'h0);
    bus_rd(OFF_RESULT, {26'h0, ID_UPPER, ID_VERSION});
    bus_wr(OFF_CMD, 8'h7E, 2'h0);
    bus_rd(OFF_RESULT, {26'h0, ST0_INVALID});
    bus_wr(8'hF0, 8'h01, 2'h2);
    bus_rd(8'hF0, {2'h2, 32'h0});
    for (int i = 0; i < 6; i++) begin
      b2 = 8'($urandom);
      b2[4] = 1'b0;
      b2[1] = 1'b1;
      b2[3:2] = 2'(i % 3);
      b3 = 8'($urandom) & 8'hF0;
      b4 = 8'($urandom);
      b5 = 8'($urandom) & 8'h05;
      data_rate <= 2'($urandom);
      tape_setup <= 2'($urandom);
      mode_cmd(b2, b3, b4, b5);
      cmp("opts", 32'(exp_opts(b2, b3, b4, b5)), 32'(opts));
      if (b4[7:6] != 2'h3) begin
        repeat (3) @(posedge aclk);
        cmp("density", 32'(b4[7:6] == 2'h1), 32'(density_select_out));
      end
    end
    for (int k = 0; k < 2; k++) begin
      mode_cmd(8'h82, 8'hE0, 8'hC8, 8'h05);
      param_lock <= k[0];
      soft_reset <= 1'b1;
      @(posedge aclk);
      soft_reset <= 1'b0;
      repeat (2) @(posedge aclk);
      cmp("opts", 32'(exp_opts(8'h02, k[0] ? 8'hE0 : 8'h00, 8'hC8, 8'h05)), 32'(opts));
    end
    final_report;
  end
endmodule
`default_nettype wire
